// file: rtl/lock_detector.sv
// Lock detector with window and phase-measurement methods.
// Assumes registers are written over a parallel port behind the serial
// interface, and that pins are asynchronous to the 10 MHz clock.
//
// Notes on behaviour
// R01 - Two methods enabled by enable field
// R02 - Lock shown on pin and status register
// R03 - Source bit clear: fixed analog window
// R04 - Source bit set: ring periods set width
// R05 - Ring test mode drives pin, disables lock
// R06 - Window lock after consecutive in-window count
// R07 - Lock sets status bit; status read-only
// R08 - One out-of-window edge clears lock, count
// R09 - Offset bits both set: window after reference
// R10 - Offset only: window ahead of reference
// R11 - Reference period count readable
// R12 - Phase error count readable, each measurement
// R13 - Compare error with low and high thresholds
// R14 - Phase lock after consecutive in-threshold cycles
// R15 - Out-of-threshold cycle clears count and lock
// R16 - Disable or reset clears counters and lock
`timescale 1ns/1ps
`default_nettype none
module lock_detector
  import lock_detect_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire pfd_pins_t PFD_PINS_IN,
  input wire logic REG_WR_IN,
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [REG_W-1:0] REG_WDATA_IN,
  output logic [REG_W-1:0] REG_RDATA_OUT,
  output logic LOCK_OUTPUT_PIN_OUT,
  output logic LOCK_INDICATION_OUT
);

  // Signed phase of a VCO edge relative to the nearest reference edge
  function automatic logic signed [17:0] edge_phase(
    input logic [CNT_W-1:0] age,
    input logic [CNT_W-1:0] period
  );
    logic signed [17:0] a;
    logic signed [17:0] p;
    a = $signed({2'b00, age});
    p = $signed({2'b00, period});
    // Late half of the period counts as early for the next edge
    if (age > (period >> 1)) begin
      edge_phase = a - p;
    end else begin
      edge_phase = a;
    end
  endfunction

  // Saturating increment of a count
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == '1) ? v : v + 16'h0001;
  endfunction

  pfd_pins_t pin_level;  // Synchronised levels
  pfd_pins_t pin_rise;  // One-cycle rising edges

  pin_sync u_sync (
    .SYS_CLK_IN(SYS_CLK_IN),
    .RESETN_IN(RESETN_IN),
    .PINS_IN(PFD_PINS_IN),
    .LEVEL_OUT(pin_level),
    .RISE_OUT(pin_rise)
  );

  // Writable registers
  logic [REG_W-1:0] lock_detect_enable;
  logic [REG_W-1:0] lock_window_offset_ctrl;
  logic [REG_W-1:0] phase_lock_thresholds;
  logic [REG_W-1:0] window_lock_config;
  logic [REG_W-1:0] output_pin_select;
  logic [REG_W-1:0] rdata;  // Registered read answer
  logic [REG_W-1:0] next_lock_detect_enable;
  logic [REG_W-1:0] next_lock_window_offset_ctrl;
  logic [REG_W-1:0] next_phase_lock_thresholds;
  logic [REG_W-1:0] next_window_lock_config;
  logic [REG_W-1:0] next_output_pin_select;
  logic [REG_W-1:0] next_rdata;

  // Measurement state
  logic [CNT_W-1:0] ref_age;  // Cycles since last reference edge
  logic [CNT_W-1:0] ref_period;  // Last full reference period
  logic [CNT_W-1:0] phase_acc;  // Detector-active cycles this period
  logic [CNT_W-1:0] phase_error;  // Last completed phase error
  logic [CNT_W-1:0] next_ref_age;
  logic [CNT_W-1:0] next_ref_period;
  logic [CNT_W-1:0] next_phase_acc;
  logic [CNT_W-1:0] next_phase_error;

  // Ring oscillator model
  logic [1:0] ring_div;  // Divider for the ring speed
  logic ring_toggle;  // Oscillator waveform for the test pin
  logic [1:0] next_ring_div;
  logic next_ring_toggle;

  // Lock state of both methods
  logic [CNT_W-1:0] win_cnt;
  logic win_lock;
  logic [PH_CNT_W-1:0] ph_cnt;
  logic ph_lock;
  logic [CNT_W-1:0] next_win_cnt;
  logic next_win_lock;
  logic [PH_CNT_W-1:0] next_ph_cnt;
  logic next_ph_lock;

  // Decoded controls
  logic en_window;
  logic en_phase;
  logic ring_test;
  logic lock_flag;
  logic [2:0] win_width;
  logic [1:0] win_speed;
  logic [CNT_W-1:0] half_window;
  logic signed [17:0] center;
  logic signed [17:0] phase_err;
  logic in_window;
  logic [6:0] thr_lo;
  logic [6:0] thr_hi;
  logic in_thresholds;

  // Control decode
  always_comb begin
    en_window = lock_detect_enable[EN_WINDOW_BIT];  // R01
    en_phase = lock_detect_enable[EN_PHASE_BIT];  // R01
    ring_test = window_lock_config[RING_TEST_BIT]
      && (output_pin_select[7:0] == RING_TEST_SEL);  // R05
    win_width = window_lock_config[WIN_WIDTH_LSB +: 3];
    win_speed = window_lock_config[WIN_SPEED_LSB +: 2];
    thr_lo = phase_lock_thresholds[THR_LO_LSB +: 7];
    thr_hi = phase_lock_thresholds[THR_HI_LSB +: 7];
  end

  // Window half width: fixed analog, or half of ring periods times speed+1
  always_comb begin
    if (window_lock_config[WIN_SOURCE_BIT]) begin
      half_window = (({13'h0000, win_width}
        * ({14'h0000, win_speed} + 16'h0001)) >> 1);  // R04
      if (half_window == 16'h0000) begin
        half_window = 16'h0001;  // A window is never narrower than a cycle
      end
    end else begin
      half_window = CNT_W'(ANALOG_HALF_CYC);  // R03
    end
  end

  // Window centre moved by the fixed offset
  always_comb begin
    if (!lock_window_offset_ctrl[OFFSET_ON_BIT]) begin
      center = 18'sh00000;
    end else if (lock_window_offset_ctrl[OFFSET_AFTER_BIT]) begin
      center = 18'(OFFSET_CYC);  // R09
    end else begin
      center = -18'(OFFSET_CYC);  // R10
    end
    // Age as seen after the edge, so a coincident VCO edge reads zero
    phase_err = edge_phase(pin_rise.ref_edge ? '0 : ref_age + 16'h0001,
      ref_period) - center;
    // Comparison is symmetric, so the absolute value suffices
    if (phase_err < 0) begin
      in_window = (-phase_err) <= $signed({2'b00, half_window});
    end else begin
      in_window = phase_err <= $signed({2'b00, half_window});
    end
  end

  // Register file: writes, read mux
  always_comb begin
    next_lock_detect_enable = lock_detect_enable;
    next_lock_window_offset_ctrl = lock_window_offset_ctrl;
    next_phase_lock_thresholds = phase_lock_thresholds;
    next_window_lock_config = window_lock_config;
    next_output_pin_select = output_pin_select;
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        LOCK_DETECT_ENABLE_ADDR: begin
          next_lock_detect_enable = REG_WDATA_IN;
        end
        LOCK_WINDOW_OFFSET_CTRL_ADDR: begin
          next_lock_window_offset_ctrl = REG_WDATA_IN;
        end
        PHASE_LOCK_THRESHOLDS_ADDR: begin
          next_phase_lock_thresholds = REG_WDATA_IN;
        end
        WINDOW_LOCK_CONFIG_ADDR: begin
          next_window_lock_config = REG_WDATA_IN;
        end
        OUTPUT_PIN_SELECT_ADDR: begin
          next_output_pin_select = REG_WDATA_IN;
        end
        // Read-only and unmapped offsets ignore writes
        default: begin
          next_output_pin_select = output_pin_select;  // R07
        end
      endcase
    end
    case (REG_ADDR_IN)
      LOCK_DETECT_ENABLE_ADDR: next_rdata = lock_detect_enable;
      LOCK_WINDOW_OFFSET_CTRL_ADDR: next_rdata = lock_window_offset_ctrl;
      PHASE_LOCK_THRESHOLDS_ADDR: next_rdata = phase_lock_thresholds;
      WINDOW_LOCK_CONFIG_ADDR: next_rdata = window_lock_config;
      OUTPUT_PIN_SELECT_ADDR: next_rdata = output_pin_select;
      REFERENCE_PERIOD_COUNT_ADDR: begin
        next_rdata = {14'h0000, ref_period};  // R11
      end
      PHASE_ERROR_COUNT_ADDR: begin
        next_rdata = {14'h0000, phase_error};  // R12
      end
      LOCK_STATUS_ADDR: begin
        next_rdata = '0;
        next_rdata[STATUS_LOCK_BIT] = lock_flag;  // R02 R07
        next_rdata[STATUS_WIN_BIT] = win_lock;
        next_rdata[STATUS_PH_BIT] = ph_lock;
      end
      // Unmapped offsets read as zero
      default: next_rdata = '0;
    endcase
  end

  // Register file flops
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lock_detect_enable <= REG_RESET;
      lock_window_offset_ctrl <= REG_RESET;
      phase_lock_thresholds <= REG_RESET;
      window_lock_config <= REG_RESET;
      output_pin_select <= REG_RESET;
      rdata <= '0;
    end else begin
      lock_detect_enable <= next_lock_detect_enable;
      lock_window_offset_ctrl <= next_lock_window_offset_ctrl;
      phase_lock_thresholds <= next_phase_lock_thresholds;
      window_lock_config <= next_window_lock_config;
      output_pin_select <= next_output_pin_select;
      rdata <= next_rdata;
    end
  end

  // Delay-line model: period and phase error counted in clock cycles
  always_comb begin
    next_ring_div = ring_div;
    next_ring_toggle = ring_toggle;
    // Ring divider ticks every speed+1 cycles
    if (ring_div >= win_speed) begin
      next_ring_div = 2'b00;
      next_ring_toggle = ~ring_toggle;
    end else begin
      next_ring_div = ring_div + 2'b01;
    end
    // Detector active in either direction adds to the error
    if (pin_level.pfd_up || pin_level.pfd_dn) begin
      next_phase_acc = sat_inc(phase_acc);
    end else begin
      next_phase_acc = phase_acc;
    end
    next_ref_age = sat_inc(ref_age);
    next_ref_period = ref_period;
    next_phase_error = phase_error;
    if (pin_rise.ref_edge) begin
      next_ref_period = sat_inc(ref_age);  // R11
      next_phase_error = next_phase_acc;  // R12
      next_phase_acc = '0;
      next_ref_age = '0;
    end
  end

  // Measurement flops
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ring_div <= '0;
      ring_toggle <= 1'b0;
      ref_age <= '0;
      ref_period <= '0;
      phase_acc <= '0;
      phase_error <= '0;
    end else begin
      ring_div <= next_ring_div;
      ring_toggle <= next_ring_toggle;
      ref_age <= next_ref_age;
      ref_period <= next_ref_period;
      phase_acc <= next_phase_acc;
      phase_error <= next_phase_error;
    end
  end

  // Threshold test on the error that is about to be stored
  always_comb begin
    in_thresholds = (next_phase_error >= {9'h000, thr_lo})
      && (next_phase_error <= {9'h000, thr_hi});  // R13 R15
  end

  // Lock counting for both methods
  always_comb begin
    next_win_cnt = win_cnt;
    next_win_lock = win_lock;
    next_ph_cnt = ph_cnt;
    next_ph_lock = ph_lock;
    // Window method, one comparison per VCO edge
    if (!en_window || ring_test) begin
      next_win_cnt = '0;  // R16 R05
      next_win_lock = 1'b0;
    end else if (pin_rise.vco_edge) begin
      if (in_window) begin
        next_win_cnt = sat_inc(win_cnt);
        // Zero target behaves as one
        if (next_win_cnt >= window_lock_config[WIN_COUNT_LSB +: 16]) begin
          next_win_lock = 1'b1;  // R06
        end
      end else begin
        next_win_cnt = '0;  // R08
        next_win_lock = 1'b0;  // R08
      end
    end
    // Phase method, one comparison per reference cycle
    if (!en_phase || ring_test) begin
      next_ph_cnt = '0;  // R16 R05
      next_ph_lock = 1'b0;
    end else if (pin_rise.ref_edge) begin
      if (in_thresholds) begin
        if (ph_cnt != '1) begin
          next_ph_cnt = ph_cnt + 10'h001;
        end
        if (next_ph_cnt >= phase_lock_thresholds[PH_COUNT_LSB +: 10]) begin
          next_ph_lock = 1'b1;  // R14
        end
      end else begin
        next_ph_cnt = '0;  // R15
        next_ph_lock = 1'b0;  // R15
      end
    end
  end

  // Lock flops; reset clears everything
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      win_cnt <= '0;  // R16
      win_lock <= 1'b0;
      ph_cnt <= '0;
      ph_lock <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      win_lock <= next_win_lock;
      ph_cnt <= next_ph_cnt;
      ph_lock <= next_ph_lock;
    end
  end

  // Combined flag: every enabled method must be locked
  assign lock_flag = (en_window || en_phase)
    && (!en_window || win_lock) && (!en_phase || ph_lock);  // R01

  // Outputs; the pin shows the ring in test mode, else the lock
  assign REG_RDATA_OUT = rdata;
  assign LOCK_INDICATION_OUT = lock_flag;
  assign LOCK_OUTPUT_PIN_OUT = ring_test ? ring_toggle : lock_flag;  // R02 R05

endmodule
`default_nettype wire

// file: inc/lock_detect_pkg.sv
// Shared constants and types for the lock-detect block.
// Assumes a 10 MHz system clock and a 30-bit parallel register port.
package lock_detect_pkg;

  // Register port geometry
  localparam int REG_W = 30;
  localparam int ADDR_W = 7;
  localparam int CNT_W = 16;
  localparam int PH_CNT_W = 10;

  // Register offsets
  localparam logic [6:0] LOCK_DETECT_ENABLE_ADDR = 7'h01;
  localparam logic [6:0] LOCK_WINDOW_OFFSET_CTRL_ADDR = 7'h05;
  localparam logic [6:0] PHASE_LOCK_THRESHOLDS_ADDR = 7'h06;
  localparam logic [6:0] WINDOW_LOCK_CONFIG_ADDR = 7'h07;
  localparam logic [6:0] OUTPUT_PIN_SELECT_ADDR = 7'h08;
  localparam logic [6:0] REFERENCE_PERIOD_COUNT_ADDR = 7'h10;
  localparam logic [6:0] PHASE_ERROR_COUNT_ADDR = 7'h11;
  localparam logic [6:0] LOCK_STATUS_ADDR = 7'h12;

  // Reset value of every writable register
  localparam logic [29:0] REG_RESET = 30'h0;

  // Field positions, enable register
  localparam int EN_WINDOW_BIT = 6;
  localparam int EN_PHASE_BIT = 7;
  localparam int EN_SPARE_BIT = 8;
  // Field positions, offset control register
  localparam int OFFSET_ON_BIT = 0;
  localparam int OFFSET_AFTER_BIT = 1;
  // Field positions, threshold register
  localparam int THR_LO_LSB = 0;
  localparam int THR_HI_LSB = 7;
  localparam int PH_COUNT_LSB = 14;
  // Field positions, window config register
  localparam int WIN_COUNT_LSB = 0;
  localparam int WIN_WIDTH_LSB = 16;
  localparam int WIN_SPEED_LSB = 19;
  localparam int RING_TEST_BIT = 21;
  localparam int WIN_SOURCE_BIT = 22;
  // Status register lock bits: combined, window and phase
  localparam int STATUS_LOCK_BIT = 2;
  localparam int STATUS_WIN_BIT = 0;
  localparam int STATUS_PH_BIT = 1;

  // Output-select code that routes the ring oscillator to the pin
  localparam logic [7:0] RING_TEST_SEL = 8'hc1;

  // Timing, in ns and in 10 MHz cycles
  localparam int SYS_CLK_KHZ = 10000;
  localparam int ANALOG_HALF_WINDOW_NS = 10;
  localparam int OFFSET_DELAY_NS = 200;
  localparam int ANALOG_HALF_RAW = ANALOG_HALF_WINDOW_NS * SYS_CLK_KHZ / 1000000;
  localparam int ANALOG_HALF_CYC = (ANALOG_HALF_RAW < 1) ? 1 : ANALOG_HALF_RAW;
  localparam int OFFSET_RAW = OFFSET_DELAY_NS * SYS_CLK_KHZ / 1000000;
  localparam int OFFSET_CYC = (OFFSET_RAW < 1) ? 1 : OFFSET_RAW;

  // Edge inputs from the phase detector and dividers
  typedef struct packed {
    logic ref_edge;
    logic vco_edge;
    logic pfd_up;
    logic pfd_dn;
  } pfd_pins_t;

endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser and rising-edge detect for the detector pins.
// Assumes the pins are asynchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import lock_detect_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire pfd_pins_t PINS_IN,
  output pfd_pins_t LEVEL_OUT,
  output pfd_pins_t RISE_OUT
);

  pfd_pins_t meta;  // First stage, read only by the second
  pfd_pins_t stable;  // Second stage, safe to use
  pfd_pins_t prev;  // Delayed copy for edge detect
  pfd_pins_t next_meta;
  pfd_pins_t next_stable;
  pfd_pins_t next_prev;

  // Next values of the chain
  always_comb begin
    next_meta = PINS_IN;
    next_stable = meta;
    next_prev = stable;
  end

  // Registers of the chain
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign LEVEL_OUT = stable;
  // Edge found only after both stages, never on the first
  assign RISE_OUT = stable & ~prev;

endmodule
`default_nettype wire

// file: tb/lock_detector_chk.sv
// Concurrent checks on the lock detector top ports.
// Assumes one clock domain and the package register map.
`timescale 1ns/1ps
`default_nettype none
module lock_detector_chk
  import lock_detect_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire pfd_pins_t PFD_PINS_IN,
  input wire logic REG_WR_IN,
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [REG_W-1:0] REG_WDATA_IN,
  input wire logic [REG_W-1:0] REG_RDATA_OUT,
  input wire logic LOCK_OUTPUT_PIN_OUT,
  input wire logic LOCK_INDICATION_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  // Shadows of the writable registers
  logic [REG_W-1:0] sh_en, sh_ofs, sh_thr, sh_win, sh_sel, sh_rd;
  logic rw_hit, mapped, ring_md;
  // Track writes exactly as the port takes them
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sh_en <= '0;
      sh_ofs <= '0;
      sh_thr <= '0;
      sh_win <= '0;
      sh_sel <= '0;
    end else if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        LOCK_DETECT_ENABLE_ADDR: sh_en <= REG_WDATA_IN;
        LOCK_WINDOW_OFFSET_CTRL_ADDR: sh_ofs <= REG_WDATA_IN;
        PHASE_LOCK_THRESHOLDS_ADDR: sh_thr <= REG_WDATA_IN;
        WINDOW_LOCK_CONFIG_ADDR: sh_win <= REG_WDATA_IN;
        OUTPUT_PIN_SELECT_ADDR: sh_sel <= REG_WDATA_IN;
        default: ;
      endcase
    end
  end
  // Shadow value for the address on the port
  always_comb begin
    rw_hit = 1'b1;
    case (REG_ADDR_IN)
      LOCK_DETECT_ENABLE_ADDR: sh_rd = sh_en;
      LOCK_WINDOW_OFFSET_CTRL_ADDR: sh_rd = sh_ofs;
      PHASE_LOCK_THRESHOLDS_ADDR: sh_rd = sh_thr;
      WINDOW_LOCK_CONFIG_ADDR: sh_rd = sh_win;
      OUTPUT_PIN_SELECT_ADDR: sh_rd = sh_sel;
      default: begin
        sh_rd = '0;
        rw_hit = 1'b0;
      end
    endcase
  end
  assign mapped = rw_hit || (REG_ADDR_IN inside {REFERENCE_PERIOD_COUNT_ADDR,
    PHASE_ERROR_COUNT_ADDR, LOCK_STATUS_ADDR});
  assign ring_md = sh_win[RING_TEST_BIT] && (sh_sel[7:0] == RING_TEST_SEL);
  // Mode sequences; two or three cycles let the mode change reach the flops
  sequence s_ring_on;
    ring_md [*3];
  endsequence
  sequence s_ring_off;
    !ring_md [*2];
  endsequence
  sequence s_idle_en;
    (sh_en[EN_PHASE_BIT:EN_WINDOW_BIT] == 2'b00) [*3];
  endsequence
  property p_rw_read;
    rw_hit |=> REG_RDATA_OUT == $past(sh_rd);
  endproperty
  property p_unmapped;
    !mapped |=> REG_RDATA_OUT == '0;
  endproperty
  property p_status;
    (REG_ADDR_IN == LOCK_STATUS_ADDR) |=>
      REG_RDATA_OUT[STATUS_LOCK_BIT] == $past(LOCK_INDICATION_OUT);
  endproperty
  property p_pin;
    s_ring_off |-> LOCK_OUTPUT_PIN_OUT == LOCK_INDICATION_OUT;
  endproperty
  property p_ring_clear;
    s_ring_on |-> !LOCK_INDICATION_OUT;
  endproperty
  property p_ring_tog;
    s_ring_on ##0 (sh_win[WIN_SPEED_LSB+:2] == 2'b00) |->
      LOCK_OUTPUT_PIN_OUT != $past(LOCK_OUTPUT_PIN_OUT);
  endproperty
  property p_idle_clear;
    s_idle_en |-> !LOCK_INDICATION_OUT;
  endproperty
  property p_reset;
    $rose(RESETN_IN) |-> !LOCK_INDICATION_OUT && REG_RDATA_OUT == '0;
  endproperty
  a_rw_read: assert property (p_rw_read)
    else $error("read data differs from written value");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_status: assert property (p_status)
    else $error("status lock bit differs from lock output");
  a_pin: assert property (p_pin)
    else $error("pin does not follow lock flag");
  a_ring_clear: assert property (p_ring_clear)
    else $error("lock set in ring test mode");
  a_ring_tog: assert property (p_ring_tog)
    else $error("ring test pin not toggling");
  a_idle_clear: assert property (p_idle_clear)
    else $error("lock set with both methods off");
  a_reset: assert property (p_reset)
    else $error("outputs not clear after reset");
endmodule
bind lock_detector lock_detector_chk lock_detector_chk_i (
  .SYS_CLK_IN(SYS_CLK_IN),
  .RESETN_IN(RESETN_IN),
  .PFD_PINS_IN(PFD_PINS_IN),
  .REG_WR_IN(REG_WR_IN),
  .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT),
  .LOCK_OUTPUT_PIN_OUT(LOCK_OUTPUT_PIN_OUT),
  .LOCK_INDICATION_OUT(LOCK_INDICATION_OUT)
);
`default_nettype wire

// file: tb/pfd_edge_model.sv
// Far-side model: reference, divided VCO and detector up and down pulses.
// Assumes a period of 0 means no edges at all; edge pulses last 2 cycles.
`timescale 1ns/1ps
`default_nettype none
module pfd_edge_model
  import lock_detect_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] period_in,
  input wire logic [7:0] vco_ofs_in,
  input wire logic [7:0] err_w_in,
  output pfd_pins_t pins_out
);
  logic [7:0] cnt; // Phase within one reference period
  initial pins_out = '0;
  // Two-cycle pulses so the synchroniser never misses an edge
  always @(posedge clk_in) begin
    #1;
    if (period_in == 8'h00) begin
      cnt = 8'h00;
      pins_out = '0;
    end else begin
      cnt = (cnt + 8'h01 >= period_in) ? 8'h00 : cnt + 8'h01;
      pins_out.ref_edge = (cnt < 8'h02);
      pins_out.vco_edge = ((cnt + period_in - vco_ofs_in) % period_in) < 8'h02;
      // Up and down share the error pulse so both inputs are exercised
      pins_out.pfd_up = (cnt >= 8'h04) && (cnt < 8'h04 + err_w_in) && !cnt[0];
      pins_out.pfd_dn = (cnt >= 8'h04) && (cnt < 8'h04 + err_w_in) && cnt[0];
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_lock_detector.sv
// Bench for the lock detector: register port, window and phase methods.
// Assumes the edge model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_lock_detector
  import lock_detect_pkg::*;
;
  typedef struct packed {
    logic [REG_W-1:0] d; // Expected read data
    logic ck; // Lock outputs must match bit 2
  } note_t;
  logic sys_clk = 1'b0;
  logic resetn, wr, rd_v, pin, lock;
  logic mon_v = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [REG_W-1:0] wdata, rdata, d;
  logic [7:0] period, vco_ofs, err_w;
  pfd_pins_t pins;
  int error_cnt, n_tests, n;
  note_t notes[$];
  logic [ADDR_W-1:0] rw_a[5] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h08};
  logic [ADDR_W-1:0] all_a[9] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h08,
    7'h10, 7'h11, 7'h12, 7'h20};
  lock_detector lock_detector_i (
    .SYS_CLK_IN(sys_clk),
    .RESETN_IN(resetn),
    .PFD_PINS_IN(pins),
    .REG_WR_IN(wr),
    .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata),
    .LOCK_OUTPUT_PIN_OUT(pin),
    .LOCK_INDICATION_OUT(lock)
  );
  pfd_edge_model pfd_edge_model_i (
    .clk_in(sys_clk),
    .period_in(period),
    .vco_ofs_in(vco_ofs),
    .err_w_in(err_w),
    .pins_out(pins)
  );
  always #50 sys_clk = ~sys_clk;
  task automatic cmp_word(input logic [REG_W-1:0] got, e);
    n_tests++;
    if (got !== e) begin
      error_cnt++;
      $display("[ERR] %0t read %h expected %h", $time, got, e);
    end
  endtask
  task automatic cmp_bit(input logic got, e);
    n_tests++;
    if (got !== e) begin
      error_cnt++;
      $display("[ERR] %0t lock output %b expected %b", $time, got, e);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
    @(posedge sys_clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge sys_clk);
    #1 wr = 1'b0;
  endtask
  // Note the expectation, then present the address for one cycle
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e,
    input logic ck);
    @(posedge sys_clk);
    #1 addr = a;
    rd_v = 1'b1;
    notes.push_back('{e, ck});
    @(posedge sys_clk);
    #1 rd_v = 1'b0;
  endtask
  // Change the far side, then let enough periods pass for a verdict
  task automatic model(input logic [7:0] o, e, input int periods);
    @(posedge sys_clk);
    #1 vco_ofs = o;
    err_w = e;
    repeat (periods * 40) @(posedge sys_clk);
  endtask
  // Count pin changes; speed 0 makes the ring toggle each cycle
  task automatic ring_check;
    int tog;
    logic last;
    tog = 0;
    last = pin;
    repeat (16) begin
      @(posedge sys_clk);
      #1 tog += (pin !== last);
      last = pin;
    end
    cmp_bit(tog == 16, 1'b1);
  endtask
  task automatic end_sim;
    if (notes.size() != 0) begin
      error_cnt++;
      $display("[ERR] %0t reads left unchecked", $time);
    end
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Read data lands one edge after the address; old value seen here
  always @(posedge sys_clk) begin
    if (mon_v) begin
      if (notes.size() == 0) begin
        error_cnt++;
        $display("[ERR] %0t read without note", $time);
      end else begin
        cmp_word(rdata, notes[0].d);
        if (notes[0].ck) begin
          cmp_bit(lock, notes[0].d[STATUS_LOCK_BIT]);
          cmp_bit(pin, notes[0].d[STATUS_LOCK_BIT]);
        end
        void'(notes.pop_front());
      end
    end
    mon_v <= rd_v;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    $display("[ERR] %0t run too long", $time);
    end_sim();
  end
  initial begin
    {resetn, wr, rd_v, addr, wdata} = '0;
    {period, vco_ofs, err_w} = '0;
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(32'h0c89));
    repeat (12) @(posedge sys_clk);
    #1 resetn = 1'b1;
    foreach (all_a[i]) rd_reg(all_a[i], '0, 1'b1);
    foreach (rw_a[i]) begin
      // Ring test bit kept clear so the pin stays a lock output here
      d = REG_W'($urandom) & ~30'h200000;
      wr_reg(rw_a[i], d);
      rd_reg(rw_a[i], d, 1'b0);
    end
    wr_reg(LOCK_STATUS_ADDR, '1);
    wr_reg(7'h20, '1);
    rd_reg(LOCK_STATUS_ADDR, '0, 1'b1);
    rd_reg(7'h20, '0, 1'b0);
    foreach (rw_a[i]) wr_reg(rw_a[i], '0);
    n = 2 + ($urandom % 5);
    period = 8'd40;
    wr_reg(WINDOW_LOCK_CONFIG_ADDR, REG_W'(n));
    wr_reg(LOCK_DETECT_ENABLE_ADDR, 30'h40);
    model(8'd0, 8'd0, n + 3);
    rd_reg(LOCK_STATUS_ADDR, 30'h5, 1'b1);
    model(8'd5, 8'd0, 2);
    rd_reg(LOCK_STATUS_ADDR, '0, 1'b1);
    wr_reg(WINDOW_LOCK_CONFIG_ADDR, 30'h5f0000 | REG_W'(n));
    model(8'd5, 8'd0, n + 3);
    rd_reg(LOCK_STATUS_ADDR, 30'h5, 1'b1);
    wr_reg(WINDOW_LOCK_CONFIG_ADDR, 30'h600000 | REG_W'(n));
    wr_reg(OUTPUT_PIN_SELECT_ADDR, 30'hc1);
    ring_check();
    rd_reg(LOCK_STATUS_ADDR, '0, 1'b0);
    wr_reg(OUTPUT_PIN_SELECT_ADDR, '0);
    wr_reg(WINDOW_LOCK_CONFIG_ADDR, REG_W'(n));
    wr_reg(LOCK_WINDOW_OFFSET_CTRL_ADDR, 30'h3);
    model(8'd2, 8'd0, n + 3);
    rd_reg(LOCK_STATUS_ADDR, 30'h5, 1'b1);
    model(8'd38, 8'd0, 2);
    rd_reg(LOCK_STATUS_ADDR, '0, 1'b1);
    wr_reg(LOCK_WINDOW_OFFSET_CTRL_ADDR, 30'h1);
    model(8'd38, 8'd0, n + 3);
    rd_reg(LOCK_STATUS_ADDR, 30'h5, 1'b1);
    wr_reg(LOCK_DETECT_ENABLE_ADDR, '0);
    rd_reg(LOCK_STATUS_ADDR, '0, 1'b1);
    wr_reg(LOCK_WINDOW_OFFSET_CTRL_ADDR, '0);
    wr_reg(PHASE_LOCK_THRESHOLDS_ADDR, 30'h303 | (REG_W'(n) << 14));
    wr_reg(LOCK_DETECT_ENABLE_ADDR, 30'h80);
    model(8'd0, 8'd3, n + 3);
    rd_reg(REFERENCE_PERIOD_COUNT_ADDR, 30'd40, 1'b0);
    rd_reg(PHASE_ERROR_COUNT_ADDR, 30'd3, 1'b0);
    rd_reg(LOCK_STATUS_ADDR, 30'h6, 1'b1);
    model(8'd0, 8'd7, 2);
    rd_reg(PHASE_ERROR_COUNT_ADDR, 30'd7, 1'b0);
    rd_reg(LOCK_STATUS_ADDR, '0, 1'b1);
    model(8'd0, 8'd6, n + 3);
    rd_reg(LOCK_STATUS_ADDR, 30'h6, 1'b1);
    wr_reg(LOCK_DETECT_ENABLE_ADDR, 30'hc0);
    model(8'd0, 8'd6, n + 3);
    rd_reg(LOCK_STATUS_ADDR, 30'h7, 1'b1);
    model(8'd0, 8'd2, 2);
    rd_reg(LOCK_STATUS_ADDR, 30'h1, 1'b1);
    @(posedge sys_clk);
    #1 resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1'b1;
    rd_reg(LOCK_STATUS_ADDR, '0, 1'b1);
    rd_reg(LOCK_DETECT_ENABLE_ADDR, '0, 1'b0);
    repeat (4) @(posedge sys_clk);
    end_sim();
  end
endmodule
`default_nettype wire
